// *** core/pca_agent.sv ***
`timescale 1ns/100ps
module pca_agent #(
    parameter int ID_W = 8,
    parameter int ADDR_W = 32,
    parameter int DATA_W = 64
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Identity
    input wire logic [ID_W-1:0] MY_ID,
    input wire logic [ID_W-1:0] MEM_ID,
    // Local processor request and answer
    input wire logic LREQ_VALID,
    input wire logic [1:0] LREQ_KIND,
    input wire logic [ADDR_W-1:0] LREQ_ADDR,
    input wire logic LREQ_COLLIDE,
    output logic LRSP_VALID,
    output logic [1:0] LRSP_CODE,
    output logic [DATA_W-1:0] LRSP_DATA,
    output logic LRSP_DATA_VALID,
    // Incoming packets (responses and external requests)
    input wire logic RX_VALID,
    input wire logic [3:0] RX_TYPE,
    input wire logic [ID_W-1:0] RX_SRCID,
    input wire logic [ID_W-1:0] RX_SECID,
    input wire logic [ADDR_W-1:0] RX_ADDR,
    input wire logic [DATA_W-1:0] RX_DATA,
    input wire logic RX_COLLIDE,
    output logic RX_READY,
    output logic COLL_VALID,
    // Outgoing packets
    output logic TX_VALID,
    output logic [3:0] TX_TYPE,
    output logic [ID_W-1:0] TX_DESTID,
    output logic [ID_W-1:0] TX_SRCID,
    output logic [ID_W-1:0] TX_SECID,
    output logic [ADDR_W-1:0] TX_ADDR,
    output logic TX_HAS_DATA,
    input wire logic TX_READY,
    // Cache hierarchy
    output logic SNP_REQ,
    output logic [1:0] SNP_CMD,
    input wire logic SNP_RSP_VALID,
    input wire logic [1:0] SNP_RSP_STATE,
    input wire logic [DATA_W-1:0] SNP_PUSH_DATA,
    output logic CSET_VALID,
    output logic [1:0] CSET_STATE,
    // Status
    output logic PROTO_ERR,
    output logic TRK_BUSY
);
    // ------------------------------------------------------------
    // Response decode shared by both machines
    // ------------------------------------------------------------
    function automatic logic is_resp(input logic [3:0] t);
        is_resp = (t == pca_pkg::TT_DONE) || (t == pca_pkg::TT_DONE_INTV) ||
                  (t == pca_pkg::TT_DATA_ONLY) || (t == pca_pkg::TT_RETRY) ||
                  (t == pca_pkg::TT_INTV) || (t == pca_pkg::TT_NOT_OWNER);
    endfunction

    pca_snoop_if sn ();
    pca_snoop_seq u_seq (
        .clk(MCLK),
        .rst_n(RST_N),
        .sn(sn),
        .req(SNP_REQ),
        .req_cmd(SNP_CMD),
        .rsp_valid(SNP_RSP_VALID),
        .rsp_state(SNP_RSP_STATE)
    );

    // ------------------------------------------------------------
    // Local transaction tracker state
    // ------------------------------------------------------------
    pca_pkg::pca_trk_t trk, next_trk;
    logic [1:0] kind, next_kind;
    logic [ADDR_W-1:0] taddr, next_taddr;
    logic got_done, next_got_done;
    logic got_data, next_got_data;
    logic lrsp_valid, next_lrsp_valid;
    logic [1:0] lrsp_code, next_lrsp_code;
    logic [DATA_W-1:0] lrsp_data, next_lrsp_data;
    logic lrsp_dv, next_lrsp_dv;
    logic ltx_pend, next_ltx_pend;
    logic [3:0] ltx_type, next_ltx_type;
    logic [ID_W-1:0] ltx_dest, next_ltx_dest;
    logic err, next_err;

    // External handler state
    pca_pkg::pca_ext_t ext, next_ext;
    logic [3:0] etype, next_etype;
    logic [ID_W-1:0] esrc, next_esrc;
    logic [ID_W-1:0] esec, next_esec;
    logic [ADDR_W-1:0] eaddr, next_eaddr;
    logic [DATA_W-1:0] edata, next_edata;
    logic [1:0] ecst, next_ecst;
    logic snp_start;
    logic [1:0] snp_cmd;
    logic ext_tx;
    logic [3:0] etx_type;
    logic [ID_W-1:0] etx_dest;
    logic etx_data;

    logic rx_resp, rx_ereq, ltx_fire, etx_fire;
    assign rx_resp = RX_VALID && is_resp(RX_TYPE);
    assign rx_ereq = RX_VALID && !is_resp(RX_TYPE);
    // External requests wait while the handler is busy; responses always sink
    assign RX_READY = rx_resp || (ext == pca_pkg::EXT_IDLE);
    // The external handler owns the transmit port first; tracker waits
    assign etx_fire = ext_tx && TX_READY;
    assign ltx_fire = ltx_pend && !ext_tx && TX_READY;

    // ------------------------------------------------------------
    // Tracker: internal request and response machines
    // ------------------------------------------------------------
    always_comb begin
        next_trk = trk;
        next_kind = kind;
        next_taddr = taddr;
        next_got_done = got_done;
        next_got_data = got_data;
        next_lrsp_valid = 1'b0;
        next_lrsp_code = lrsp_code;
        next_lrsp_data = lrsp_data;
        next_lrsp_dv = 1'b0;
        next_ltx_pend = ltx_pend && !ltx_fire;
        next_ltx_type = ltx_type;
        next_ltx_dest = ltx_dest;
        next_err = err;
        if (LREQ_VALID) begin
            next_lrsp_valid = 1'b1;
            next_lrsp_code = pca_pkg::LRSP_RETRY;
            if (!LREQ_COLLIDE && trk == pca_pkg::TRK_IDLE) begin
                next_trk = pca_pkg::TRK_WAIT;
                next_kind = LREQ_KIND;
                next_taddr = LREQ_ADDR;
                next_got_done = 1'b0;
                next_got_data = 1'b0;
                next_ltx_pend = 1'b1;
                next_ltx_dest = MEM_ID;
                unique case (LREQ_KIND)
                    pca_pkg::LREQ_READ: next_ltx_type = pca_pkg::TT_READ_HOME;
                    pca_pkg::LREQ_RFO: next_ltx_type = pca_pkg::TT_RTO_HOME;
                    pca_pkg::LREQ_DKILL: next_ltx_type = pca_pkg::TT_DKILL_HOME;
                    pca_pkg::LREQ_IKILL: next_ltx_type = pca_pkg::TT_IKILL_HOME;
                endcase
            end
        end
        if (rx_resp) begin
            if (trk != pca_pkg::TRK_WAIT || RX_TYPE == pca_pkg::TT_INTV || RX_TYPE == pca_pkg::TT_NOT_OWNER) begin
                next_err = 1'b1;
            end else if (RX_TYPE == pca_pkg::TT_RETRY) begin
                next_ltx_pend = 1'b1;
                next_ltx_dest = (kind == pca_pkg::LREQ_RFO) ? MEM_ID : RX_SRCID;
            end else if (RX_TYPE == pca_pkg::TT_DONE) begin
                next_lrsp_valid = 1'b1;
                next_lrsp_code = (kind == pca_pkg::LREQ_READ) ? pca_pkg::LRSP_SHARED : pca_pkg::LRSP_EXCL;
                next_lrsp_dv = (kind == pca_pkg::LREQ_READ) || (kind == pca_pkg::LREQ_RFO);
                next_lrsp_data = RX_DATA;
                next_trk = pca_pkg::TRK_IDLE;
            end else if (kind == pca_pkg::LREQ_DKILL || kind == pca_pkg::LREQ_IKILL) begin
                next_err = 1'b1;
            end else if (RX_TYPE == pca_pkg::TT_DONE_INTV) begin
                next_got_done = 1'b1;
                if (got_data) begin
                    next_trk = pca_pkg::TRK_IDLE;
                end
            end else begin
                next_got_data = 1'b1;
                next_lrsp_valid = 1'b1;
                next_lrsp_code = (kind == pca_pkg::LREQ_READ) ? pca_pkg::LRSP_SHARED : pca_pkg::LRSP_EXCL;
                next_lrsp_dv = 1'b1;
                next_lrsp_data = RX_DATA;
                if (got_done) begin
                    next_trk = pca_pkg::TRK_IDLE;
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            trk <= pca_pkg::TRK_IDLE;
            kind <= 2'h0;
            taddr <= '0;
            got_done <= 1'b0;
            got_data <= 1'b0;
            lrsp_valid <= 1'b0;
            lrsp_code <= 2'h0;
            lrsp_data <= '0;
            lrsp_dv <= 1'b0;
            ltx_pend <= 1'b0;
            ltx_type <= 4'h0;
            ltx_dest <= '0;
            err <= 1'b0;
        end else begin
            trk <= next_trk;
            kind <= next_kind;
            taddr <= next_taddr;
            got_done <= next_got_done;
            got_data <= next_got_data;
            lrsp_valid <= next_lrsp_valid;
            lrsp_code <= next_lrsp_code;
            lrsp_data <= next_lrsp_data;
            lrsp_dv <= next_lrsp_dv;
            ltx_pend <= next_ltx_pend;
            ltx_type <= next_ltx_type;
            ltx_dest <= next_ltx_dest;
            err <= next_err;
        end
    end

    // ------------------------------------------------------------
    // External request machine
    // ------------------------------------------------------------
    always_comb begin
        next_ext = ext;
        next_etype = etype;
        next_esrc = esrc;
        next_esec = esec;
        next_eaddr = eaddr;
        next_edata = edata;
        next_ecst = ecst;
        snp_start = 1'b0;
        snp_cmd = pca_pkg::SNP_READ;
        ext_tx = 1'b0;
        etx_type = pca_pkg::TT_DONE;
        etx_dest = esrc;
        etx_data = 1'b0;
        CSET_VALID = 1'b0;
        CSET_STATE = pca_pkg::CST_INVALID;
        unique case (ext)
            pca_pkg::EXT_IDLE: begin
                if (rx_ereq && !RX_COLLIDE) begin
                    next_etype = RX_TYPE;
                    next_esrc = RX_SRCID;
                    next_esec = RX_SECID;
                    next_eaddr = RX_ADDR;
                    next_ext = pca_pkg::EXT_SNOOP;
                end
            end
            pca_pkg::EXT_SNOOP: begin
                snp_start = 1'b1;
                snp_cmd = (etype == pca_pkg::TT_READ_OWNER) ? pca_pkg::SNP_READ :
                          (etype == pca_pkg::TT_IKILL_SHARER) ? pca_pkg::SNP_IKILL : pca_pkg::SNP_RTO;
                if (!sn.busy) begin
                    next_ext = pca_pkg::EXT_WAIT;
                end
            end
            pca_pkg::EXT_WAIT: begin
                // Push data stands only beside the answer, a cycle before done
                next_edata = SNP_RSP_VALID ? SNP_PUSH_DATA : edata;
                if (sn.done) begin
                    next_ecst = sn.state;
                    next_ext = pca_pkg::EXT_SEND;
                    // Owner reads keep a shared copy, owner RTOs and sharer kills drop the line
                    CSET_VALID = (sn.state != pca_pkg::CST_INVALID);
                    CSET_STATE = (etype == pca_pkg::TT_READ_OWNER) ? pca_pkg::CST_SHARED : pca_pkg::CST_INVALID;
                end
            end
            pca_pkg::EXT_SEND: begin
                ext_tx = 1'b1;
                if (etype == pca_pkg::TT_DKILL_SHARER || etype == pca_pkg::TT_IKILL_SHARER) begin
                    etx_type = pca_pkg::TT_DONE;
                    if (ecst == pca_pkg::CST_MODIFIED) begin
                        ext_tx = 1'b0;
                    end
                end else if (ecst == pca_pkg::CST_INVALID) begin
                    etx_type = pca_pkg::TT_NOT_OWNER;
                end else if (esrc == esec || ecst != pca_pkg::CST_MODIFIED) begin
                    etx_type = pca_pkg::TT_INTV;
                    etx_data = 1'b1;
                    ext_tx = (ecst == pca_pkg::CST_MODIFIED);
                end else begin
                    etx_type = pca_pkg::TT_DATA_ONLY;
                    etx_dest = esec;
                    etx_data = 1'b1;
                end
                if (!ext_tx || TX_READY) begin
                    next_ext = (ext_tx && etx_type == pca_pkg::TT_DATA_ONLY) ? pca_pkg::EXT_SEND2 : pca_pkg::EXT_IDLE;
                end
            end
            pca_pkg::EXT_SEND2: begin
                ext_tx = 1'b1;
                etx_type = pca_pkg::TT_INTV;
                etx_data = 1'b1;
                if (TX_READY) begin
                    next_ext = pca_pkg::EXT_IDLE;
                end
            end
            default: next_ext = pca_pkg::EXT_IDLE;
        endcase
    end

    // Error on a bad cache answer to an external request
    logic ext_err;
    assign ext_err = (ext == pca_pkg::EXT_SEND) && (ecst == pca_pkg::CST_MODIFIED || ecst == pca_pkg::CST_SHARED) &&
                     (etype == pca_pkg::TT_DKILL_SHARER || etype == pca_pkg::TT_IKILL_SHARER ?
                      ecst == pca_pkg::CST_MODIFIED : ecst == pca_pkg::CST_SHARED);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ext <= pca_pkg::EXT_IDLE;
            etype <= 4'h0;
            esrc <= '0;
            esec <= '0;
            eaddr <= '0;
            edata <= '0;
            ecst <= 2'h0;
        end else begin
            ext <= next_ext;
            etype <= next_etype;
            esrc <= next_esrc;
            esec <= next_esec;
            eaddr <= next_eaddr;
            edata <= next_edata;
            ecst <= next_ecst;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sn.start = snp_start;
    assign sn.cmd = snp_cmd;
    assign COLL_VALID = rx_ereq && RX_COLLIDE && (ext == pca_pkg::EXT_IDLE);
    assign TX_VALID = ext_tx || ltx_pend;
    assign TX_TYPE = ext_tx ? etx_type : ltx_type;
    assign TX_DESTID = ext_tx ? etx_dest : ltx_dest;
    assign TX_SRCID = MY_ID;
    assign TX_SECID = MY_ID;
    assign TX_ADDR = ext_tx ? eaddr : taddr;
    assign TX_HAS_DATA = ext_tx && etx_data;
    assign LRSP_VALID = lrsp_valid;
    assign LRSP_CODE = lrsp_code;
    assign LRSP_DATA = lrsp_data;
    assign LRSP_DATA_VALID = lrsp_dv;
    assign PROTO_ERR = err || ext_err;
    assign TRK_BUSY = (trk == pca_pkg::TRK_WAIT);
endmodule

// *** core/pca_pkg.sv ***
package pca_pkg;
    // -------------------------------------------------------------
    // Local processor request kinds
    // -------------------------------------------------------------
    localparam logic [1:0] LREQ_READ = 2'h0;
    localparam logic [1:0] LREQ_RFO = 2'h1;
    localparam logic [1:0] LREQ_DKILL = 2'h2;
    localparam logic [1:0] LREQ_IKILL = 2'h3;

    // Answers to the local processor
    localparam logic [1:0] LRSP_RETRY = 2'h0;
    localparam logic [1:0] LRSP_SHARED = 2'h1;
    localparam logic [1:0] LRSP_EXCL = 2'h2;

    // -------------------------------------------------------------
    // Packet transaction codes on the interconnect side
    // -------------------------------------------------------------
    localparam logic [3:0] TT_READ_HOME = 4'h0;
    localparam logic [3:0] TT_RTO_HOME = 4'h1;
    localparam logic [3:0] TT_DKILL_HOME = 4'h2;
    localparam logic [3:0] TT_IKILL_HOME = 4'h3;
    localparam logic [3:0] TT_READ_OWNER = 4'h4;
    localparam logic [3:0] TT_RTO_OWNER = 4'h5;
    localparam logic [3:0] TT_DKILL_SHARER = 4'h6;
    localparam logic [3:0] TT_IKILL_SHARER = 4'h7;
    localparam logic [3:0] TT_DONE = 4'h8;
    localparam logic [3:0] TT_DONE_INTV = 4'h9;
    localparam logic [3:0] TT_DATA_ONLY = 4'hA;
    localparam logic [3:0] TT_RETRY = 4'hB;
    localparam logic [3:0] TT_INTV = 4'hC;
    localparam logic [3:0] TT_NOT_OWNER = 4'hD;

    // Local cache snoop commands and answers
    localparam logic [1:0] SNP_READ = 2'h0;
    localparam logic [1:0] SNP_RTO = 2'h1;
    localparam logic [1:0] SNP_IKILL = 2'h2;
    localparam logic [1:0] CST_INVALID = 2'h0;
    localparam logic [1:0] CST_SHARED = 2'h1;
    localparam logic [1:0] CST_MODIFIED = 2'h2;
    localparam logic [1:0] CST_RETRY = 2'h3;

    // Outstanding local transaction tracker state
    typedef enum logic [1:0] {
        TRK_IDLE = 2'b00,
        TRK_WAIT = 2'b01
    } pca_trk_t;

    // External request handler state
    typedef enum logic [2:0] {
        EXT_IDLE = 3'b000,
        EXT_SNOOP = 3'b001,
        EXT_WAIT = 3'b010,
        EXT_SEND = 3'b011,
        EXT_SEND2 = 3'b100
    } pca_ext_t;
endpackage

// *** core/pca_snoop_if.sv ***
`timescale 1ns/100ps
// Snoop path between the agent and its cache-side sequencer
interface pca_snoop_if;
    logic start;
    logic [1:0] cmd;
    logic busy;
    logic done;
    logic [1:0] state;
    modport agent (output start, output cmd, input busy, input done, input state);
    modport seq (input start, input cmd, output busy, output done, output state);
endinterface

// *** core/pca_snoop_seq.sv ***
`timescale 1ns/100ps
// Issues a snoop to the caches and repeats it until they answer validly
module pca_snoop_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Agent side
    pca_snoop_if.seq sn,
    // Cache side
    output logic req,
    output logic [1:0] req_cmd,
    input wire logic rsp_valid,
    input wire logic [1:0] rsp_state
);
    logic active, next_active;
    logic [1:0] cmd, next_cmd;
    logic done, next_done;
    logic [1:0] state, next_state;

    // A retry answer keeps the request raised, so the snoop spins
    always_comb begin
        next_active = active;
        next_cmd = cmd;
        next_done = 1'b0;
        next_state = state;
        if (!active && sn.start) begin
            next_active = 1'b1;
            next_cmd = sn.cmd;
        end else if (active && rsp_valid && rsp_state != pca_pkg::CST_RETRY) begin
            next_active = 1'b0;
            next_done = 1'b1;
            next_state = rsp_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            cmd <= 2'h0;
            done <= 1'b0;
            state <= 2'h0;
        end else begin
            active <= next_active;
            cmd <= next_cmd;
            done <= next_done;
            state <= next_state;
        end
    end

    assign req = active;
    assign req_cmd = cmd;
    assign sn.busy = active;
    assign sn.done = done;
    assign sn.state = state;
endmodule

// *** verif/pca_cache_model.sv ***
`timescale 1ns/100ps
// Cache hierarchy stand-in: retries a snoop a set number of times, then answers
module pca_cache_model #(
    parameter int DATA_W = 64
) (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Snoop port
    input logic req,
    output logic rsp_valid,
    output logic [1:0] rsp_state,
    output logic [DATA_W-1:0] push_data,
    // Scenario control
    input logic [1:0] state,
    input logic [1:0] retries,
    input logic [DATA_W-1:0] line
);
    logic [1:0] cnt;
    logic [1:0] st;
    logic done;
    // Answers every other cycle; done blocks a second answer to a request still dropping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            cnt <= 2'h0;
            st <= 2'h0;
            done <= 1'b0;
        end else begin
            rsp_valid <= req && !rsp_valid && !done;
            if (!req) begin
                cnt <= 2'h0;
                done <= 1'b0;
            end else if (!rsp_valid && !done) begin
                st <= (cnt < retries) ? pca_pkg::CST_RETRY : state;
                done <= (cnt >= retries);
                cnt <= cnt + 2'h1;
            end
        end
    end
    // Outside an answer the lines show garbage, not the last value
    assign rsp_state = rsp_valid ? st : ~st;
    assign push_data = rsp_valid ? line : ~line;
endmodule

// *** verif/pca_agent_checker.sv ***
`timescale 1ns/100ps
module pca_agent_checker #(
    parameter int ID_W = 8
) (
    // Clock, reset and ids
    input logic MCLK, RST_N,
    input logic [ID_W-1:0] MEM_ID, RX_SRCID, TX_DESTID,
    // Local side
    input logic LREQ_VALID, LREQ_COLLIDE, LRSP_VALID, LRSP_DATA_VALID, TRK_BUSY,
    input logic [1:0] LREQ_KIND, LRSP_CODE,
    // Packets and caches
    input logic RX_VALID, RX_READY, RX_COLLIDE, COLL_VALID, TX_VALID, SNP_REQ, SNP_RSP_VALID, CSET_VALID,
    input logic [3:0] RX_TYPE, TX_TYPE,
    input logic [1:0] SNP_CMD, SNP_RSP_STATE, CSET_STATE
);
    logic [1:0] kind, next_kind, scmd;
    logic [ID_W-1:0] rsrc, next_rsrc;
    logic [3:0] ext, next_ext;
    logic alloc, xreq;
    // Remember kind of held entry, last retrying responder, last external type
    assign alloc = LREQ_VALID && !LREQ_COLLIDE && !TRK_BUSY;
    assign xreq = RX_VALID && RX_READY && RX_TYPE inside {[pca_pkg::TT_READ_OWNER:pca_pkg::TT_IKILL_SHARER]};
    assign next_kind = alloc ? LREQ_KIND : kind;
    assign next_rsrc = (RX_VALID && RX_TYPE == pca_pkg::TT_RETRY) ? RX_SRCID : rsrc;
    assign next_ext = xreq ? RX_TYPE : ext;
    // Only the owner read leaves a copy behind, so only it snoops with a plain read
    assign scmd = (ext == pca_pkg::TT_READ_OWNER) ? pca_pkg::SNP_READ :
        (ext == pca_pkg::TT_IKILL_SHARER) ? pca_pkg::SNP_IKILL : pca_pkg::SNP_RTO;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            kind <= 2'h0;
            rsrc <= '0;
            ext <= 4'h0;
        end else begin
            kind <= next_kind;
            rsrc <= next_rsrc;
            ext <= next_ext;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    lrsp_retry_a: assert property (LREQ_VALID && !RX_VALID |=> LRSP_VALID && LRSP_CODE == pca_pkg::LRSP_RETRY)
        else $error("local request not retried");
    home_req_a: assert property (alloc |=> TRK_BUSY ##[0:30] (TX_VALID && TX_TYPE == {2'b00, kind} && TX_DESTID == MEM_ID))
        else $error("home request missing");
    done_answer_a: assert property (RX_VALID && RX_TYPE == pca_pkg::TT_DONE && TRK_BUSY |=> LRSP_VALID && !TRK_BUSY
        && LRSP_CODE == (kind == 2'h0 ? pca_pkg::LRSP_SHARED : pca_pkg::LRSP_EXCL) && LRSP_DATA_VALID == !kind[1])
        else $error("completion answer wrong");
    retry_dest_a: assert property (RX_VALID && RX_TYPE == pca_pkg::TT_RETRY && TRK_BUSY |=> ##[0:30] (TX_VALID
        && TX_TYPE == {2'b00, kind} && TX_DESTID == (kind == pca_pkg::LREQ_RFO ? MEM_ID : rsrc)))
        else $error("reissue wrong");
    coll_path_a: assert property (xreq && RX_COLLIDE |-> COLL_VALID ##1 !SNP_REQ)
        else $error("collision not diverted");
    snoop_cmd_a: assert property (xreq && !RX_COLLIDE |=> ##1 (SNP_REQ && SNP_CMD == scmd))
        else $error("snoop command wrong");
    snoop_hold_a: assert property (SNP_REQ && !(SNP_RSP_VALID && SNP_RSP_STATE != pca_pkg::CST_RETRY) |=> SNP_REQ)
        else $error("snoop dropped early");
    cset_inv_a: assert property (CSET_VALID && ext != pca_pkg::TT_READ_OWNER |-> CSET_STATE == pca_pkg::CST_INVALID)
        else $error("line not invalidated");
endmodule
bind pca_agent pca_agent_checker #(.ID_W(ID_W)) pca_agent_checker_i (.*);

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] MY_ID, MEM_ID, RX_SRCID, RX_SECID, TX_DESTID, TX_SRCID, TX_SECID, s;
    logic [31:0] LREQ_ADDR, RX_ADDR, TX_ADDR, a;
    logic [31:0] seed = 32'h0000_68E0;
    logic [63:0] LRSP_DATA, RX_DATA, SNP_PUSH_DATA, line;
    logic [3:0] RX_TYPE, TX_TYPE;
    logic [1:0] LREQ_KIND, LRSP_CODE, SNP_CMD, SNP_RSP_STATE, CSET_STATE, c_state, c_retries, c;
    logic LREQ_VALID, LREQ_COLLIDE, LRSP_VALID, LRSP_DATA_VALID, RX_VALID, RX_COLLIDE, RX_READY, COLL_VALID;
    logic TX_VALID, TX_HAS_DATA, TX_READY, SNP_REQ, SNP_RSP_VALID, CSET_VALID, PROTO_ERR, TRK_BUSY;
    logic [3:0] xt [8] = '{pca_pkg::TT_READ_OWNER, pca_pkg::TT_READ_OWNER, pca_pkg::TT_READ_OWNER,
        pca_pkg::TT_RTO_OWNER, pca_pkg::TT_RTO_OWNER, pca_pkg::TT_DKILL_SHARER, pca_pkg::TT_IKILL_SHARER,
        pca_pkg::TT_IKILL_SHARER};
    logic [1:0] xs [8] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
    int n_errors = 0;
    int checks = 0;
    pca_agent pca_agent_i (.*);
    pca_cache_model cache_i (.clk(MCLK), .rst_n(RST_N), .req(SNP_REQ), .rsp_valid(SNP_RSP_VALID),
        .rsp_state(SNP_RSP_STATE), .push_data(SNP_PUSH_DATA), .state(c_state), .retries(c_retries), .line(line));
    // 200 MHz clock
    always #2.5 MCLK = ~MCLK;
    // Xorshift keeps every run identical
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait; a hang ends the run as a failure
    task automatic hold_until(ref logic sig);
        int i;
        for (i = 0; i < 60 && sig !== 1'b1; i++) @(negedge MCLK);
        if (i == 60) begin
            n_errors++;
            final_report();
        end
    endtask
    // Takes one outgoing packet after a random stall
    task automatic take(logic [3:0] tt, logic [7:0] dst);
        hold_until(TX_VALID);
        `CHK("tx type", tt, TX_TYPE)
        `CHK("tx dest", dst, TX_DESTID)
        `CHK("tx ids", {MY_ID, MY_ID}, {TX_SRCID, TX_SECID})
        `CHK("tx addr", a, TX_ADDR)
        `CHK("tx data", tt inside {pca_pkg::TT_INTV, pca_pkg::TT_DATA_ONLY}, TX_HAS_DATA)
        repeat (rnd() % 3) @(negedge MCLK);
        TX_READY = 1'b1;
        @(negedge MCLK);
        TX_READY = 1'b0;
    endtask
    task automatic lreq(logic [1:0] k, logic col, logic busy);
        @(negedge MCLK);
        {LREQ_VALID, LREQ_KIND, LREQ_COLLIDE, LREQ_ADDR} = {1'b1, k, col, rnd()};
        @(negedge MCLK);
        LREQ_VALID = 1'b0;
        `CHK("lrsp retry", {1'b1, pca_pkg::LRSP_RETRY}, {LRSP_VALID, LRSP_CODE})
        `CHK("busy", busy, TRK_BUSY)
    endtask
    // Response packet; v, code and dv give the expected answer to the processor
    task automatic rsp(logic [3:0] tt, logic v, logic [1:0] code, logic dv, logic busy);
        logic [63:0] d;
        d = {rnd(), rnd()};
        @(negedge MCLK);
        {RX_VALID, RX_TYPE, RX_SRCID, RX_DATA} = {1'b1, tt, s, d};
        #1 `CHK("rx ready", 1'b1, RX_READY)
        @(negedge MCLK);
        {RX_VALID, RX_DATA} = {1'b0, ~d};
        `CHK("lrsp valid", v, LRSP_VALID)
        if (v) `CHK("lrsp code", code, LRSP_CODE)
        `CHK("data valid", dv, LRSP_DATA_VALID)
        if (dv) `CHK("data", d, LRSP_DATA)
        `CHK("busy", busy, TRK_BUSY)
    endtask
    task automatic ext(logic [3:0] tt, logic [7:0] sec, logic [1:0] st, logic col);
        @(negedge MCLK);
        {c_state, c_retries, line} = {st, 2'(rnd() % 3), rnd(), rnd()};
        {RX_VALID, RX_TYPE, RX_SRCID, RX_SECID, RX_COLLIDE, RX_ADDR} = {1'b1, tt, s, sec, col, rnd()};
        #1 `CHK("coll valid", col, COLL_VALID)
        `CHK("rx ready", 1'b1, RX_READY)
        @(negedge MCLK);
        {RX_VALID, RX_COLLIDE} = 2'b00;
    endtask
    initial begin
        {LREQ_VALID, LREQ_COLLIDE, RX_VALID, RX_COLLIDE, TX_READY, LREQ_KIND, RX_TYPE, c_state, c_retries} = '0;
        {LREQ_ADDR, RX_ADDR, RX_DATA, RX_SRCID, RX_SECID, line, s} = '0;
        {MY_ID, MEM_ID} = 16'h3C5A;
        repeat (10) @(negedge MCLK);
        RST_N = 1'b1;
        // Local flows: plain completion, data before completion, completion before data
        for (int k = 0; k < 4; k++) begin
            for (int v = 0; v < 3; v++) begin
                if (k < 2 || v == 0) begin
                    s = rnd();
                    c = (k == 0) ? pca_pkg::LRSP_SHARED : pca_pkg::LRSP_EXCL;
                    lreq(2'(k), 1'b0, 1'b1);
                    a = LREQ_ADDR;
                    take(4'(k), MEM_ID);
                    lreq(2'(k ^ 1), 1'b0, 1'b1);
                    rsp(pca_pkg::TT_RETRY, 1'b0, c, 1'b0, 1'b1);
                    take(4'(k), (k == 1) ? MEM_ID : s);
                    if (v == 0) rsp(pca_pkg::TT_DONE, 1'b1, c, !k[1], 1'b0);
                    if (v == 1) rsp(pca_pkg::TT_DATA_ONLY, 1'b1, c, 1'b1, 1'b1);
                    if (v != 0) rsp(pca_pkg::TT_DONE_INTV, 1'b0, c, 1'b0, v == 2);
                    if (v == 2) rsp(pca_pkg::TT_DATA_ONLY, 1'b1, c, 1'b1, 1'b0);
                end
            end
        end
        lreq(pca_pkg::LREQ_READ, 1'b1, 1'b0);
        // External requests against every cache answer that has a reply, save an invalid answer to a DKILL sharer request
        for (int i = 0; i < 8; i++) begin
            s = rnd();
            ext(xt[i], (i == 0) ? s : s ^ 8'h80, xs[i], 1'b0);
            a = RX_ADDR;
            if (xs[i] == pca_pkg::CST_MODIFIED && i != 0) take(pca_pkg::TT_DATA_ONLY, s ^ 8'h80);
            if (xs[i] == pca_pkg::CST_MODIFIED) take(pca_pkg::TT_INTV, s);
            else take(i < 5 ? pca_pkg::TT_NOT_OWNER : pca_pkg::TT_DONE, s);
        end
        ext(pca_pkg::TT_READ_OWNER, s, pca_pkg::CST_MODIFIED, 1'b1);
        repeat (8) @(negedge MCLK);
        `CHK("no tx", 1'b0, TX_VALID)
        `CHK("proto err", 1'b0, PROTO_ERR)
        // Modified answer to a kill is a paradox: error and no reply
        ext(pca_pkg::TT_DKILL_SHARER, s, pca_pkg::CST_MODIFIED, 1'b0);
        hold_until(PROTO_ERR);
        repeat (4) @(negedge MCLK);
        `CHK("no tx", 1'b0, TX_VALID)
        rsp(pca_pkg::TT_DONE, 1'b0, c, 1'b0, 1'b0);
        `CHK("proto err", 1'b1, PROTO_ERR)
        final_report();
    end
endmodule
